// File: common/cxs_consts.vh
`ifndef CXS_CONSTS_VH
`define CXS_CONSTS_VH

// Vector numbers of the exception sources
`define CXS_VEC_RESET      8'h00
`define CXS_VEC_BUS_ERR    8'h02
`define CXS_VEC_ADDR_ERR   8'h03
`define CXS_VEC_ILLEGAL    8'h04
`define CXS_VEC_DIV_ZERO   8'h05
`define CXS_VEC_BOUNDS     8'h06
`define CXS_VEC_TRAP_CC    8'h07
`define CXS_VEC_PRIV       8'h08
`define CXS_VEC_TRACE      8'h09
`define CXS_VEC_FP_UNIMP   8'h0b
`define CXS_VEC_FP_TRAP    8'h0c
`define CXS_VEC_AUTOVEC    8'h18
`define CXS_VEC_TRAP_BASE  8'h20

// Status register fields
`define CXS_SR_MASTER_BIT  12
`define CXS_SR_SUPER_BIT   13
`define CXS_SR_TRACE_BIT   15
`define CXS_SR_RESET_VAL   16'h2700
`define CXS_SR_MASK_LO     8
`define CXS_SR_MASK_HI     10

// Interrupt level that ignores the mask
`define CXS_IRQ_NMI_LVL    3'h7

// Vector offset shift (vector number times four)
`define CXS_VEC_SHIFT      2

// Reset vector base value
`define CXS_VBR_RESET      32'h0000_0000

// Source index in the pending vector, lowest index wins
`define CXS_SRC_RESET      0
`define CXS_SRC_BUS_ERR    1
`define CXS_SRC_ADDR_ERR   2
`define CXS_SRC_MMU        3
`define CXS_SRC_TRACE      4
`define CXS_SRC_IRQ        5
`define CXS_SRC_ILLEGAL    6
`define CXS_SRC_FP_UNIMP   7
`define CXS_SRC_PRIV       8
`define CXS_SRC_INSTR      9
`define CXS_NUM_SRC        10

`endif

// File: logic/cxs_prio_pick.v
`timescale 1ns/10ps
`default_nettype none

// Fixed priority picker: lowest set index wins
module cxs_prio_pick #(
    parameter N = 10
) (
    // Requests
    input  wire [N-1:0] req_i,
    // One-hot grant
    output wire [N-1:0] gnt_o,
    output wire         any_o
);
    assign gnt_o = req_i & ~(req_i - {{(N-1){1'b0}}, 1'b1});
    assign any_o = |req_i;
endmodule

`default_nettype wire

// File: logic/cxs_exception_seq.v
`timescale 1ns/10ps
`default_nettype none
`include "cxs_consts.vh"

module cxs_exception_seq (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        reset_i,
    // External pins (asynchronous)
    input  wire [2:0]  irq_level_i,
    input  wire        bus_err_pin_i,
    // Core status and control
    input  wire [15:0] sr_i,
    input  wire [31:0] vbr_i,
    input  wire [31:0] pc_i,
    input  wire        trace_pending_i,
    // Instruction and address faults
    input  wire        illegal_i,
    input  wire        fp_unimp_i,
    input  wire        priv_viol_i,
    input  wire        odd_fetch_i,
    input  wire        instr_trap_i,
    input  wire [7:0]  instr_vec_i,
    // Memory management faults
    input  wire        mmu_access_viol_i,
    input  wire        mmu_bad_desc_i,
    // Bus controller
    input  wire        bus_ack_i,
    input  wire        bus_err_i,
    input  wire [31:0] bus_rdata_i,
    output wire        bus_req_o,
    output reg  [31:0] bus_addr_o,
    // Core side results
    output reg  [15:0] sr_copy_o,
    output reg  [15:0] sr_new_o,
    output reg  [7:0]  vec_num_o,
    output reg         use_master_sp_o,
    output reg         save_state_o,
    output reg  [31:0] saved_pc_o,
    output reg  [31:0] handler_pc_o,
    output reg         resume_o,
    output reg         double_fault_o,
    output wire        busy_o
);
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_COPY  = 6'h02;
    localparam [5:0] ST_VEC   = 6'h04;
    localparam [5:0] ST_SAVE  = 6'h08;
    localparam [5:0] ST_FETCH = 6'h10;
    localparam [5:0] ST_HALT  = 6'h20;

    reg [5:0]  state_q;
    reg [2:0]  irq_s1_q, irq_s2_q;
    reg        berr_s1_q, berr_s2_q;
    reg [9:0]  grant_q;
    reg        in_vec_read_q;
    wire [9:0] pend;
    wire [9:0] gnt;
    wire       any;
    reg  [5:0] state_d;
    reg [15:0] sr_new_d;
    reg        use_msp_d;

    // Pins pass two flops before use; only the second flop is read
    // Level bits cross one by one, so a source must hold its level a few cycles
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_s1_q <= 3'h0;
            irq_s2_q <= 3'h0;
        end else begin
            irq_s1_q <= irq_level_i;
            irq_s2_q <= irq_s1_q;
        end
    end

    // The bus error pin has its own pair, as it may change at any time
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            berr_s1_q <= 1'b0;
            berr_s2_q <= 1'b0;
        end else begin
            berr_s1_q <= bus_err_pin_i;
            berr_s2_q <= berr_s1_q;
        end
    end

    // Level 7 is unmaskable; others must exceed the mask
    function irq_accept;
        input [2:0] lvl;
        input [2:0] mask;
        begin
            irq_accept = (lvl == `CXS_IRQ_NMI_LVL) || (lvl > mask);
        end
    endfunction

    wire irq_ok = irq_accept(irq_s2_q, sr_i[`CXS_SR_MASK_HI:`CXS_SR_MASK_LO]);

    assign pend[`CXS_SRC_RESET]    = 1'b0;
    assign pend[`CXS_SRC_BUS_ERR]  = berr_s2_q;
    assign pend[`CXS_SRC_ADDR_ERR] = odd_fetch_i;
    assign pend[`CXS_SRC_MMU]      = mmu_access_viol_i | mmu_bad_desc_i;
    assign pend[`CXS_SRC_TRACE]    = trace_pending_i & sr_i[`CXS_SR_TRACE_BIT];
    assign pend[`CXS_SRC_IRQ]      = irq_ok;
    assign pend[`CXS_SRC_ILLEGAL]  = illegal_i;
    assign pend[`CXS_SRC_FP_UNIMP] = fp_unimp_i;
    assign pend[`CXS_SRC_PRIV]     = priv_viol_i;
    assign pend[`CXS_SRC_INSTR]    = instr_trap_i;

    // Trace sits above the interrupt so it acts as the highest interrupt
    cxs_prio_pick #(
        .N(`CXS_NUM_SRC)
    ) u_pick (
        .req_i(pend),
        .gnt_o(gnt),
        .any_o(any)
    );

    function [7:0] vec_of;
        input [9:0] g;
        input [7:0] ivec;
        input [2:0] lvl;
        begin
            case (1'b1)
                g[`CXS_SRC_BUS_ERR]:  vec_of = `CXS_VEC_BUS_ERR;
                g[`CXS_SRC_ADDR_ERR]: vec_of = `CXS_VEC_ADDR_ERR;
                g[`CXS_SRC_MMU]:      vec_of = `CXS_VEC_BUS_ERR;
                g[`CXS_SRC_TRACE]:    vec_of = `CXS_VEC_TRACE;
                g[`CXS_SRC_IRQ]:      vec_of = `CXS_VEC_AUTOVEC + {5'h00, lvl};
                g[`CXS_SRC_ILLEGAL]:  vec_of = `CXS_VEC_ILLEGAL;
                g[`CXS_SRC_FP_UNIMP]: vec_of = `CXS_VEC_FP_UNIMP;
                g[`CXS_SRC_PRIV]:     vec_of = `CXS_VEC_PRIV;
                g[`CXS_SRC_INSTR]:    vec_of = ivec;
                default:              vec_of = `CXS_VEC_RESET;
            endcase
        end
    endfunction

    // A vector read fault while handling a bus error or reset cannot recover
    function fatal_src;
        input [9:0] g;
        begin
            fatal_src = g[`CXS_SRC_BUS_ERR] | g[`CXS_SRC_RESET];
        end
    endfunction

    // Vector offset is number times four
    wire [31:0] vec_off  = {22'h0, vec_num_o, 2'b00};
    // Address from vector base plus offset
    wire [31:0] vec_addr = vbr_i + vec_off;

    // Single long-word read held until ack or error
    // Driven from a flop so the request cannot glitch on a state change
    assign bus_req_o = in_vec_read_q;
    assign busy_o    = (state_q != ST_IDLE);

    // Next state; sources seen while busy are not stored and must be held
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (any) begin
                    state_d = ST_COPY;
                end
            end

            ST_COPY: begin
                state_d = ST_VEC;
            end

            ST_VEC: begin
                state_d = ST_SAVE;
            end

            ST_SAVE: begin
                state_d = ST_FETCH;
            end

            ST_FETCH: begin
                if (bus_err_i) begin
                    if (fatal_src(grant_q)) begin
                        state_d = ST_HALT;
                    end else begin
                        state_d = ST_COPY;
                    end
                end else if (bus_ack_i) begin
                    state_d = ST_IDLE;
                end
            end

            ST_HALT: begin
                // Only reset leaves this state
                state_d = ST_HALT;
            end

            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // New status: supervisor set, trace cleared except on reset
    // An interrupt also leaves the master stack and raises the mask to its level
    always @* begin
        sr_new_d  = sr_copy_o | (16'h0001 << `CXS_SR_SUPER_BIT);
        use_msp_d = sr_copy_o[`CXS_SR_MASTER_BIT];
        if (grant_q[`CXS_SRC_IRQ]) begin
            sr_new_d[`CXS_SR_MASTER_BIT]              = 1'b0;
            sr_new_d[`CXS_SR_MASK_HI:`CXS_SR_MASK_LO] = irq_s2_q;
            use_msp_d                                 = 1'b0;
        end
        if (!grant_q[`CXS_SRC_RESET]) begin
            sr_new_d[`CXS_SR_TRACE_BIT] = 1'b0;
        end
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            // Reset beats every other source and fetches vector zero
            state_q         <= ST_COPY;
            grant_q         <= 10'h001;
            in_vec_read_q   <= 1'b0;
            bus_addr_o      <= 32'h0000_0000;
            sr_copy_o       <= `CXS_SR_RESET_VAL;
            sr_new_o        <= `CXS_SR_RESET_VAL;
            vec_num_o       <= `CXS_VEC_RESET;
            use_master_sp_o <= 1'b0;
            save_state_o    <= 1'b0;
            saved_pc_o      <= 32'h0000_0000;
            handler_pc_o    <= 32'h0000_0000;
            resume_o        <= 1'b0;
            double_fault_o  <= 1'b0;
        end else begin
            save_state_o <= 1'b0;
            resume_o     <= 1'b0;
            state_q      <= state_d;
            case (state_q)
                ST_IDLE: begin
                    // Only one source accepted per entry
                    if (any) begin
                        grant_q <= gnt;
                    end
                end

                ST_COPY: begin
                    // Status copy comes first
                    sr_copy_o <= grant_q[`CXS_SRC_RESET] ? `CXS_SR_RESET_VAL : sr_i;
                end

                ST_VEC: begin
                    // Vector number second
                    vec_num_o       <= vec_of(grant_q, instr_vec_i, irq_s2_q);
                    sr_new_o        <= sr_new_d;
                    use_master_sp_o <= use_msp_d;
                end

                ST_SAVE: begin
                    // State save last, skipped for reset
                    save_state_o  <= ~grant_q[`CXS_SRC_RESET];
                    saved_pc_o    <= pc_i;
                    bus_addr_o    <= vec_addr;
                    in_vec_read_q <= 1'b1;
                end

                ST_FETCH: begin
                    if (bus_err_i) begin
                        // Fault during vector read; a second one halts
                        in_vec_read_q <= 1'b0;
                        if (fatal_src(grant_q)) begin
                            double_fault_o <= 1'b1;
                        end else begin
                            // Re-enter as a bus error so the fault is reported, not lost
                            grant_q <= 10'h002;
                        end
                    end else if (bus_ack_i) begin
                        // Handler address then resume
                        handler_pc_o  <= bus_rdata_i;
                        resume_o      <= 1'b1;
                        in_vec_read_q <= 1'b0;
                    end
                end

                default: begin
                    // Halt holds every result until reset
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// File: tb/cxs_seq_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "cxs_consts.vh"
module cxs_seq_props (
    // Watched ports
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic [15:0] sr_i,
    input wire logic [31:0] vbr_i,
    input wire logic        bus_ack_i,
    input wire logic        bus_err_i,
    input wire logic [31:0] bus_rdata_i,
    input wire logic        bus_req_o,
    input wire logic [31:0] bus_addr_o,
    input wire logic [15:0] sr_copy_o,
    input wire logic [7:0]  vec_num_o,
    input wire logic        use_master_sp_o,
    input wire logic        save_state_o,
    input wire logic [31:0] handler_pc_o,
    input wire logic        resume_o,
    input wire logic        busy_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_taken; !busy_o ##1 busy_o; endsequence
    sequence s_prep; !bus_req_o [*3] ##1 bus_req_o; endsequence
    AST_ORDER: assert property (s_taken |-> s_prep)
        else $error("vector read not after three steps");
    AST_SR_COPY: assert property (s_taken |=> sr_copy_o == sr_i)
        else $error("status copy wrong");
    AST_VEC_ADDR: assert property (save_state_o |->
        bus_addr_o == vbr_i + {vec_num_o, 2'b00}) else $error("vector address wrong");
    AST_REQ_HOLD: assert property (bus_req_o && !bus_ack_i && !bus_err_i |=> bus_req_o)
        else $error("vector request dropped");
    AST_RESUME: assert property (bus_req_o && bus_ack_i |=> resume_o && !bus_req_o)
        else $error("no resume after vector read");
    AST_HANDLER: assert property (bus_ack_i |=> handler_pc_o == $past(bus_rdata_i))
        else $error("handler address wrong");
    AST_ISP: assert property (save_state_o && vec_num_o > `CXS_VEC_AUTOVEC &&
        vec_num_o < `CXS_VEC_TRAP_BASE |-> !use_master_sp_o) else $error("interrupt on master");
    AST_MSP: assert property (save_state_o && vec_num_o == `CXS_VEC_ILLEGAL |->
        use_master_sp_o == sr_copy_o[`CXS_SR_MASTER_BIT]) else $error("stack choice wrong");
endmodule
bind cxs_exception_seq cxs_seq_props cxs_seq_props_inst (.*);
`default_nettype wire

// File: tb/cxs_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module cxs_bus_model (
    // Clock, reset and test controls
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  wait_i,
    input  wire logic        err_mode_i,
    // Bus controller side
    input  wire logic        req_i,
    input  wire logic [31:0] addr_i,
    output var logic         ack_o,
    output var logic         err_o,
    output wire logic [31:0] rdata_o
);
    logic [3:0] cnt_q;
    // Data is valid only with the acknowledge, inverted otherwise
    assign rdata_o = ack_o ? addr_i + 32'h1000 : ~(addr_i + 32'h1000);
    always @(posedge ref_clk_i) begin
        ack_o <= 1'b0;
        err_o <= 1'b0;
        if (reset_i || !req_i || ack_o || err_o) begin
            cnt_q <= 4'h0;
        end else if (cnt_q == wait_i) begin
            ack_o <= !err_mode_i;
            err_o <= err_mode_i;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_cxs_exception_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "cxs_consts.vh"
module tb_cxs_exception_seq;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [2:0]  irq_level_i = 3'h0;
    logic [15:0] sr_i = 16'h2000;
    logic [31:0] vbr_i = 32'h4000;
    logic [31:0] pc_i = 32'h0120;
    logic        trace_pending_i = 1'b0;
    logic [7:0]  instr_vec_i = 8'h25;
    logic [4:0]  flt = 5'h00;
    logic [2:0]  ext = 3'h0;
    logic [3:0]  wait_cyc = 4'h2;
    logic        err_mode = 1'b0;
    logic        illegal_i, fp_unimp_i, priv_viol_i, odd_fetch_i, instr_trap_i, bus_err_pin_i;
    logic        mmu_access_viol_i, mmu_bad_desc_i, bus_ack_i, bus_err_i, bus_req_o, busy_o;
    logic        use_master_sp_o, save_state_o, resume_o, double_fault_o;
    logic [31:0] bus_rdata_i, bus_addr_o, saved_pc_o, handler_pc_o;
    logic [15:0] sr_copy_o, sr_new_o;
    logic [7:0]  vec_num_o;
    int          fails = 0;
    int          n_tests = 0;
    assign {instr_trap_i, priv_viol_i, fp_unimp_i, illegal_i, odd_fetch_i} = flt;
    assign {bus_err_pin_i, mmu_bad_desc_i, mmu_access_viol_i} = ext;
    always #50 ref_clk_i = ~ref_clk_i;
    cxs_exception_seq cxs_exception_seq_inst (.*);
    cxs_bus_model cxs_bus_model_inst (.ref_clk_i, .reset_i, .wait_i(wait_cyc), .err_mode_i(err_mode),
        .req_i(bus_req_o), .addr_i(bus_addr_o), .ack_o(bus_ack_i), .err_o(bus_err_i),
        .rdata_o(bus_rdata_i));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic fin(input logic [31:0] a);
        for (int i = 0; i < 60 && resume_o !== 1'b1; i++) @(negedge ref_clk_i);
        chk("handler_pc", a + 32'h1000, handler_pc_o);
    endtask
    task automatic exc(input logic [7:0] v, input logic m);
        for (int i = 0; i < 60 && save_state_o !== 1'b1; i++) @(negedge ref_clk_i);
        // Interrupt, trace and ext sources are dropped once taken so they are not taken twice
        irq_level_i = 3'h0;
        trace_pending_i = 1'b0;
        ext = 3'h0;
        chk("vec_num", {24'h0, v}, vec_num_o);
        chk("master_sp", {31'h0, m}, use_master_sp_o);
        chk("saved_pc", pc_i, saved_pc_o);
        chk("vec_addr", vbr_i + {v, 2'b00}, bus_addr_o);
        fin(vbr_i + {v, 2'b00});
    endtask
    task automatic t_faults;
        logic [7:0] v [5];
        v = '{`CXS_VEC_ADDR_ERR, `CXS_VEC_ILLEGAL, `CXS_VEC_FP_UNIMP, `CXS_VEC_PRIV, 8'h25};
        sr_i = 16'h3000;
        wait_cyc = 4'h7;
        flt = 5'h1f;
        for (int k = 0; k < 5; k++) begin
            exc(v[k], 1'b1);
            flt[k] = 1'b0;
        end
    endtask
    task automatic t_irq;
        wait_cyc = 4'h0;
        irq_level_i = 3'h5;
        exc(`CXS_VEC_AUTOVEC + 8'h05, 1'b0);
        chk("sr_new_m", 32'h0, {31'h0, sr_new_o[`CXS_SR_MASTER_BIT]});
        sr_i = 16'ha000;
        trace_pending_i = 1'b1;
        irq_level_i = 3'h7;
        exc(`CXS_VEC_TRACE, 1'b0);
        for (int k = 0; k < 3; k++) begin
            ext = 3'h1 << k;
            exc(`CXS_VEC_BUS_ERR, 1'b0);
        end
    endtask
    task automatic t_err;
        err_mode = 1'b1;
        flt = 5'h02;
        for (int i = 0; i < 200 && double_fault_o !== 1'b1; i++) @(negedge ref_clk_i);
        chk("double_fault", 32'h1, {31'h0, double_fault_o});
        chk("fault_vec", {24'h0, `CXS_VEC_BUS_ERR}, vec_num_o);
        flt = 5'h00;
        err_mode = 1'b0;
        reset_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        reset_i = 1'b0;
        chk("halt_clear", 32'h0, {31'h0, double_fault_o});
        fin(vbr_i);
    endtask
    task complete_run;
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge ref_clk_i);
        reset_i = 1'b0;
        fin(vbr_i);
        t_faults;
        t_irq;
        t_err;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        complete_run;
    end
endmodule
`default_nettype wire
